// >>> shared/jtp_pkg.sv
// Constants and types shared by the test access port block.
package jtp_pkg;
    localparam int IR_WIDTH = 4;
    localparam int DR_WIDTH = 16;
    localparam logic [IR_WIDTH-1:0] IR_RESET = 4'hF;
    localparam logic [IR_WIDTH-1:0] IR_BYPASS = 4'hF;
    localparam logic [IR_WIDTH-1:0] IR_USER_DR = 4'h2;
    localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
    localparam int SYNC_STAGES = 2;
    localparam real LINK_PERIOD_NS = 125.0;
    localparam real MCLK_PERIOD_NS = 10.0;
    localparam int LINK_HALF_CYCLES = int'(LINK_PERIOD_NS / (2.0 * MCLK_PERIOD_NS));

    typedef enum logic [3:0] {
        TEST_LOGIC_RESET,
        RUN_TEST_IDLE,
        SELECT_DR_SCAN,
        CAPTURE_DR,
        SHIFT_DR,
        EXIT1_DR,
        PAUSE_DR,
        EXIT2_DR,
        UPDATE_DR,
        SELECT_IR_SCAN,
        CAPTURE_IR,
        SHIFT_IR,
        EXIT1_IR,
        PAUSE_IR,
        EXIT2_IR,
        UPDATE_IR
    } jtp_state_type;
endpackage

// >>> verilog/jtp_tap.sv
// Test access port controller sampling the test pins on the system clock.
// Operation
// R1: The test clock pin, found by its edges, advances all test logic and serial shifting.
// R2: Mode select is sampled at each rising test clock edge and steps the controller.
// R3: Serial data input is captured at each rising test clock edge into the active shift path.
// R4: Data output is enabled only in the shift-IR and shift-DR states and floats otherwise.
// R5: Data output changes only at a falling test clock edge; test reset and system reset instead release it at once.
// R6: A low test reset input holds the controller in its reset state.
// R7: The host asserts test reset together with system reset for a full hardware reset.
// R8: System reset alone leaves controller, instruction and data register state untouched.
// R9: Setting the pull-up disable bit turns off the pull-ups on mode select, data in and reset.
// R10: The controller is the sixteen-state boundary-scan machine, forced to reset by test reset.
`timescale 1ns/1ns
module jtp_tap #(
    parameter int IR_W = jtp_pkg::IR_WIDTH,
    parameter int DR_W = jtp_pkg::DR_WIDTH
) (
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            ce,
    input  wire logic            tck,
    input  wire logic            tms,
    input  wire logic            tdi,
    input  wire logic            trst_n,
    output logic                 tdo_o,
    output logic                 tdo_oe,
    input  wire logic            pullup_disable_control,
    output logic                 test_pullup_en,
    input  wire logic [DR_W-1:0] dr_capture_data,
    output logic [DR_W-1:0]      dr_update_data,
    output logic                 dr_update,
    output logic [IR_W-1:0]      ir_value,
    output logic                 tap_in_reset
);
    // The reset and capture codes are fixed at the package width, so the
    // instruction width cannot be changed on its own.
    if (IR_W < 2 || IR_W != jtp_pkg::IR_WIDTH || DR_W < 1) begin : g_bad_width
        $error("jtp_tap: unsupported register widths");
    end

    // Two-stage synchronisers; the extra tck stage exists only for edge finding.
    logic [1:0] tck_sync_ff;
    logic       tck_prev_ff;
    logic [1:0] tms_sync_ff;
    logic [1:0] tdi_sync_ff;
    logic [1:0] trst_sync_ff;

    // Synchronisers come out of system reset as "test reset released", so a
    // system reset never reaches the controller through them.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tck_sync_ff  <= 2'h0;
            tck_prev_ff  <= 1'b0;
            tms_sync_ff  <= 2'h3;
            tdi_sync_ff  <= 2'h3;
            trst_sync_ff <= 2'h3;
        end else if (ce) begin
            tck_sync_ff  <= {tck_sync_ff[0], tck};
            tck_prev_ff  <= tck_sync_ff[1];
            tms_sync_ff  <= {tms_sync_ff[0], tms};
            tdi_sync_ff  <= {tdi_sync_ff[0], tdi};
            trst_sync_ff <= {trst_sync_ff[0], trst_n};
        end
    end

    logic tck_rise;
    logic tck_fall;
    logic trst_act;
    assign tck_rise = ce & tck_sync_ff[1] & ~tck_prev_ff; // R1
    assign tck_fall = ce & ~tck_sync_ff[1] & tck_prev_ff; // R1
    assign trst_act = ~trst_sync_ff[1];

    jtp_pkg::jtp_state_type state_ff;
    jtp_pkg::jtp_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            jtp_pkg::TEST_LOGIC_RESET:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::TEST_LOGIC_RESET : jtp_pkg::RUN_TEST_IDLE;
            jtp_pkg::RUN_TEST_IDLE:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::SELECT_DR_SCAN : jtp_pkg::RUN_TEST_IDLE;
            jtp_pkg::SELECT_DR_SCAN:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::SELECT_IR_SCAN : jtp_pkg::CAPTURE_DR;
            jtp_pkg::CAPTURE_DR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::EXIT1_DR : jtp_pkg::SHIFT_DR;
            jtp_pkg::SHIFT_DR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::EXIT1_DR : jtp_pkg::SHIFT_DR;
            jtp_pkg::EXIT1_DR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::UPDATE_DR : jtp_pkg::PAUSE_DR;
            jtp_pkg::PAUSE_DR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::EXIT2_DR : jtp_pkg::PAUSE_DR;
            jtp_pkg::EXIT2_DR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::UPDATE_DR : jtp_pkg::SHIFT_DR;
            jtp_pkg::UPDATE_DR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::SELECT_DR_SCAN : jtp_pkg::RUN_TEST_IDLE;
            jtp_pkg::SELECT_IR_SCAN:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::TEST_LOGIC_RESET : jtp_pkg::CAPTURE_IR;
            jtp_pkg::CAPTURE_IR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::EXIT1_IR : jtp_pkg::SHIFT_IR;
            jtp_pkg::SHIFT_IR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::EXIT1_IR : jtp_pkg::SHIFT_IR;
            jtp_pkg::EXIT1_IR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::UPDATE_IR : jtp_pkg::PAUSE_IR;
            jtp_pkg::PAUSE_IR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::EXIT2_IR : jtp_pkg::PAUSE_IR;
            jtp_pkg::EXIT2_IR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::UPDATE_IR : jtp_pkg::SHIFT_IR;
            jtp_pkg::UPDATE_IR:
                nxt_state = tms_sync_ff[1] ? jtp_pkg::SELECT_DR_SCAN : jtp_pkg::RUN_TEST_IDLE;
            default:
                nxt_state = jtp_pkg::TEST_LOGIC_RESET;
        endcase
    end

    // Controller state is deliberately outside the system reset so that a
    // device reset leaves a debug session intact; only test reset clears it.
    always_ff @(posedge mclk) begin
        if (trst_act && ce) begin
            state_ff <= jtp_pkg::TEST_LOGIC_RESET; // R6 R8 R10
        end else if (tck_rise) begin
            state_ff <= nxt_state; // R2 R10
        end
    end

    logic [IR_W-1:0] ir_shift_ff;
    logic [IR_W-1:0] ir_ff;
    always_ff @(posedge mclk) begin
        // The instruction is held at its reset code for as long as the controller
        // sits in reset, however it got there.
        if (ce && (trst_act || state_ff == jtp_pkg::TEST_LOGIC_RESET)) begin
            ir_ff <= jtp_pkg::IR_RESET; // R6 R8
        end else if (tck_rise) begin
            unique case (state_ff)
                jtp_pkg::CAPTURE_IR: begin
                    ir_shift_ff <= {ir_ff[IR_W-1:2], jtp_pkg::IR_CAPTURE_LOW};
                end
                jtp_pkg::SHIFT_IR: begin
                    ir_shift_ff <= {tdi_sync_ff[1], ir_shift_ff[IR_W-1:1]}; // R3
                end
                jtp_pkg::UPDATE_IR: begin
                    ir_ff <= ir_shift_ff;
                end
                default: begin
                end
            endcase
        end
    end

    logic            user_sel;
    logic [DR_W-1:0] dr_shift_ff;
    logic            bypass_ff;
    logic            dr_update_ff;
    logic [DR_W-1:0] dr_update_data_ff;
    assign user_sel = (ir_ff == jtp_pkg::IR_USER_DR);

    always_ff @(posedge mclk) begin
        if (ce) begin
            dr_update_ff <= 1'b0;
            if (tck_rise) begin
                unique case (state_ff)
                    jtp_pkg::CAPTURE_DR: begin
                        dr_shift_ff <= dr_capture_data;
                        bypass_ff   <= 1'b0;
                    end
                    jtp_pkg::SHIFT_DR: begin
                        if (user_sel) begin
                            dr_shift_ff <= {tdi_sync_ff[1], dr_shift_ff[DR_W-1:1]}; // R3
                        end else begin
                            bypass_ff <= tdi_sync_ff[1]; // R3
                        end
                    end
                    jtp_pkg::UPDATE_DR: begin
                        if (user_sel) begin
                            dr_update_data_ff <= dr_shift_ff;
                            dr_update_ff      <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // The pin is re-registered only on a falling edge, giving the host half a
    // test clock period of setup before its next rising sample.
    logic tdo_ff;
    logic tdo_oe_ff;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tdo_ff    <= 1'b0;
            tdo_oe_ff <= 1'b0;
        end else if (ce && trst_act) begin
            // Test reset can arrive with no clock running, so the pin is
            // released at once rather than at the next fall.
            tdo_oe_ff <= 1'b0; // R4 R6
        end else if (tck_fall) begin
            tdo_oe_ff <= (state_ff == jtp_pkg::SHIFT_IR)
                       || (state_ff == jtp_pkg::SHIFT_DR); // R4 R5
            if (state_ff == jtp_pkg::SHIFT_IR) begin
                tdo_ff <= ir_shift_ff[0]; // R5
            end else begin
                tdo_ff <= user_sel ? dr_shift_ff[0] : bypass_ff; // R5
            end
        end
    end

    logic pullup_en_ff;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pullup_en_ff <= 1'b1;
        end else if (ce) begin
            pullup_en_ff <= ~pullup_disable_control; // R9
        end
    end

    assign tdo_o          = tdo_ff;
    assign tdo_oe         = tdo_oe_ff; // R4
    assign test_pullup_en = pullup_en_ff;
    assign dr_update_data = dr_update_data_ff;
    assign dr_update      = dr_update_ff;
    assign ir_value       = ir_ff;
    assign tap_in_reset   = (state_ff == jtp_pkg::TEST_LOGIC_RESET);
endmodule

// >>> testbench/jtp_tap_sva.sv
// Pin-level assertions for the test access port.
`timescale 1ns/1ns
module jtp_tap_sva #(parameter int IR_W = 4, parameter int DR_W = 16) (
    input wire logic            mclk,
    input wire logic            rst,
    input wire logic            ce,
    input wire logic            tck,
    input wire logic            trst_n,
    input wire logic            tdo_o,
    input wire logic            tdo_oe,
    input wire logic            pullup_disable_control,
    input wire logic            test_pullup_en,
    input wire logic [DR_W-1:0] dr_update_data,
    input wire logic            dr_update,
    input wire logic [IR_W-1:0] ir_value,
    input wire logic            tap_in_reset
);
    logic       tck_q = 1'b0;
    logic       armed = 1'b0;
    logic [3:0] fall_age = 4'hF;
    // The age since the last test clock fall bounds when the output may move.
    always_ff @(posedge mclk) begin
        tck_q <= tck;
        if (tap_in_reset) armed <= 1'b1;
        if (tck_q && !tck) fall_age <= 4'h0;
        else if (fall_age != 4'hF) fall_age <= fall_age + 4'h1;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence s_trst_held;
        (!trst_n && ce)[*4];
    endsequence
    a_tdo_on_fall: assert property (($changed(tdo_o) || $rose(tdo_oe)
        || ($fell(tdo_oe) && !tap_in_reset)) |-> fall_age < 4'h6)
        else $error("tdo moved away from a test clock fall");
    a_trst_resets: assert property (s_trst_held |=> tap_in_reset)
        else $error("test reset did not reset the controller");
    a_reset_ir: assert property (tap_in_reset |=> ir_value == jtp_pkg::IR_RESET)
        else $error("instruction not reset in reset state");
    a_pullup_follow: assert property (ce |=> test_pullup_en == !$past(pullup_disable_control))
        else $error("pull-up enable does not follow the disable bit");
    a_oe_not_reset: assert property (tdo_oe |-> !tap_in_reset)
        else $error("tdo driven in reset state");
    a_rst_keeps_ir: assert property (armed && $fell(rst) |-> ir_value == $past(ir_value, 4))
        else $error("system reset disturbed the instruction");
    a_update_on_rise: assert property (dr_update |-> tck && $past(tck, 2) && ir_value == jtp_pkg::IR_USER_DR)
        else $error("data update without a test clock rise");
    a_ir_on_rise: assert property ($changed(ir_value) |-> tck || tap_in_reset)
        else $error("instruction changed without a test clock rise");
endmodule
bind jtp_tap jtp_tap_sva #(.IR_W(IR_W), .DR_W(DR_W)) u_jtp_tap_sva (.mclk, .rst, .ce, .tck,
    .trst_n, .tdo_o, .tdo_oe, .pullup_disable_control, .test_pullup_en, .dr_update_data,
    .dr_update, .ir_value, .tap_in_reset);

// >>> testbench/jtp_host.sv
// Behavioural debug host that drives the test pins.
`timescale 1ns/1ns
module jtp_host (
    input wire logic mclk,
    input wire logic tdo_pin,
    output logic     tck,
    output logic     tms,
    output logic     tdi,
    output logic     trst_n
);
    int lo_extra = 0;
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        trst_n = 1'b1;
    end
    // The low phase alternates 6 and 7 cycles so the mean period is 125 ns.
    task automatic clk_bit(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (3 + lo_extra) @(posedge mclk);
        q = tdo_pin;
        lo_extra = 1 - lo_extra;
        tck <= 1'b1;
        repeat (6) @(posedge mclk);
        tck <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask
    task automatic scan(input logic ir, input int n, input logic [15:0] din,
                        output logic [15:0] dout);
        logic q;
        clk_bit(1'b0, 1'b1, q);
        clk_bit(1'b1, 1'b1, q);
        if (ir) clk_bit(1'b1, 1'b1, q);
        clk_bit(1'b0, 1'b1, q);
        clk_bit(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            clk_bit(i == n - 1, din[i], q);
            dout[i] = q;
        end
        clk_bit(1'b1, 1'b1, q);
        clk_bit(1'b0, 1'b1, q);
    endtask
    task automatic pulse_trst();
        trst_n <= 1'b0;
        repeat (26) @(posedge mclk);
        trst_n <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the test access port.
`timescale 1ns/1ns
module testbench;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        pullup_disable_control = 1'b0;
    logic [15:0] dr_capture_data = 16'h0000;
    logic [15:0] din, got, dr_m;
    logic [3:0]  ir_m, code;
    // Start value of the stimulus generator.
    logic [31:0] seed = 32'h0001_60BC;
    wire         tck, tms, tdi, trst_n, tdo_o, tdo_oe, test_pullup_en, dr_update, tap_in_reset;
    wire [15:0]  dr_update_data;
    wire [3:0]   ir_value;
    int          errors = 0, compares = 0, cycles = 0, upd_cnt = 0, exp_upd = 0;
    jtp_tap u_jtp_tap (.mclk, .rst, .ce, .tck, .tms, .tdi, .trst_n, .tdo_o, .tdo_oe,
        .pullup_disable_control, .test_pullup_en, .dr_capture_data, .dr_update_data,
        .dr_update, .ir_value, .tap_in_reset);
    jtp_host u_jtp_host (.mclk, .tdo_pin(tdo_oe ? tdo_o : 1'b1), .tck, .tms, .tdi, .trst_n);
    initial begin
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Full reset: test reset overlaps the system reset and outlasts it.
    task automatic hw_reset();
        rst <= 1'b1;
        pullup_disable_control <= 1'b0;
        fork
            u_jtp_host.pulse_trst();
            begin
                repeat (12) @(posedge mclk);
                rst <= 1'b0;
            end
        join
        check("reset state", tap_in_reset, 1'b1);
        check("reset ir", ir_value, jtp_pkg::IR_RESET);
        ir_m = jtp_pkg::IR_RESET;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (dr_update === 1'b1) upd_cnt++;
        if (cycles == 5000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        hw_reset();
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            pullup_disable_control <= seed[0];
            repeat (2) @(posedge mclk);
            check("pull-up", test_pullup_en, !seed[0]);
            code = (i == 1) ? jtp_pkg::IR_BYPASS : jtp_pkg::IR_USER_DR;
            u_jtp_host.scan(1'b1, 4, {12'h000, code}, got);
            check("ir capture", got[3:0], {ir_m[3:2], 2'b01});
            ir_m = code;
            check("ir", ir_value, ir_m);
            din = seed[31:16];
            dr_capture_data <= seed[15:0];
            u_jtp_host.scan(1'b0, 16, din, got);
            if (ir_m == jtp_pkg::IR_USER_DR) begin
                check("dr capture", got, dr_capture_data);
                dr_m = din;
                exp_upd++;
            end else begin
                check("bypass", got, {din[14:0], 1'b0});
            end
            check("dr update", dr_update_data, dr_m);
            check("updates", 16'(upd_cnt), 16'(exp_upd));
            check("tdo released", tdo_oe, 1'b0);
            if (i == 2) begin
                rst <= 1'b1;
                pullup_disable_control <= 1'b0;
                repeat (6) @(posedge mclk);
                check("oe in reset", tdo_oe, 1'b0);
                rst <= 1'b0;
                check("ir kept", ir_value, ir_m);
                check("dr kept", dr_update_data, dr_m);
                ce <= 1'b0;
                pullup_disable_control <= 1'b1;
                repeat (3) @(posedge mclk);
                check("pull-up frozen", test_pullup_en, 1'b1);
                ce <= 1'b1;
            end
        end
        hw_reset();
        print_verdict();
    end
endmodule
